// [core/crb_builder.sv]
`timescale 1ns/10ps
// Operation
// - Error-free query yields response type 0x96
// - Only generic reason codes are sent
// - Code word then flags, filters, buffer, events
// - Filter counts, VLAN modes, channels, checksum
// - Flag bit 0 reports hardware arbitration
// - Flag bit 1 reports driver status support
// - Flag bits 2,3 report flow control
// - Flag bit 4 reports all-multicast support
// - Flag bits 6:5 arbitration implementation state
// - Broadcast bits mirror broadcast filter settings
// - Multicast bits mirror multicast filter settings
// - Buffer word reports inbound buffer bytes
// - Unspecified buffer size reports zero
// - Event word uses event control bitmap
// - VLAN filter count at most 15
// - MAC filters total at most 8
// - Channel count byte reports channels
module crb_builder (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic query_valid_in,
   input wire logic query_error_in,
   input wire crb_pkg::crb_caps_type caps_in,
   input wire logic buf_size_known_in,
   input wire logic [31:0] checksum_in,
   output logic query_ready_out,
   output logic hdr_start_out,
   output logic [7:0] resp_type_out,
   output logic [31:0] word_data_out,
   output logic word_valid_out,
   output logic word_last_out,
   input wire logic word_ready_in,
   output logic busy_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      crb_pkg::crb_state_type st;
      logic [3:0] idx;
      logic err;
      logic hdr;
      logic busy;
      logic qrdy;
      crb_pkg::crb_caps_type caps;
      logic buf_known;
   } crb_builder_state_type;

   crb_builder_state_type s_q;
   crb_builder_state_type s_d;
   logic [31:0] counts;
   logic [31:0] cur_word;
   logic [31:0] flags;
   logic buf_in_ready;
   logic push;
   crb_pkg::crb_word_type buf_in;
   crb_pkg::crb_word_type buf_out;
   logic buf_out_valid;

   // Filter count word with legal limits applied
   crb_limit u_limit (
      .vlan_in(s_q.caps.vlan_count),
      .mixed_in(s_q.caps.mixed_count),
      .mcast_in(s_q.caps.mcast_count),
      .ucast_in(s_q.caps.ucast_count),
      .counts_out(counts)
   );

   // ----------------------------------------
   // Flag word and payload mux
   // ----------------------------------------
   always_comb begin
      flags = 32'h0000_0000;
      flags[crb_pkg::FLAG_HW_ARB] = s_q.caps.hw_arb;
      flags[crb_pkg::FLAG_DRV_STATUS] = s_q.caps.drv_status;
      flags[crb_pkg::FLAG_NC_TO_MC_FC] = s_q.caps.nc_to_mc_fc;
      flags[crb_pkg::FLAG_MC_TO_NC_FC] = s_q.caps.mc_to_nc_fc;
      flags[crb_pkg::FLAG_ALL_MCAST] = s_q.caps.all_mcast;
      // Reserved code 11b is never sent; it falls back to unknown
      flags[crb_pkg::FLAG_ARB_IMPL_LO +: 2] =
         (s_q.caps.arb_impl == crb_pkg::ARB_IMPL_RSVD) ? 2'h0 : s_q.caps.arb_impl;
      case (s_q.idx)
         4'h0: cur_word = s_q.err ? {crb_pkg::RESP_FAILED, crb_pkg::REASON_GENERIC_ERR}
                                  : {crb_pkg::RESP_OK, crb_pkg::REASON_NONE};
         4'h1: cur_word = flags;
         4'h2: cur_word = s_q.caps.bcast_caps;
         4'h3: cur_word = s_q.caps.mcast_caps;
         4'h4: cur_word = s_q.buf_known ? s_q.caps.buf_bytes : 32'h0000_0000;
         4'h5: cur_word = s_q.caps.aen_caps;
         4'h6: cur_word = counts;
         4'h7: cur_word = {16'h0000, s_q.caps.vlan_modes, s_q.caps.channel_count};
         default: cur_word = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.hdr = 1'b0;
      push = 1'b0;
      buf_in.data = cur_word;
      // Only the checksum word closes the response, never a payload word
      buf_in.last = 1'b0;
      case (s_q.st)
         crb_pkg::ST_IDLE: begin
            s_d.qrdy = 1'b1;
            if (query_valid_in && s_q.qrdy) begin
               s_d.st = crb_pkg::ST_SEND;
               s_d.err = query_error_in;
               s_d.caps = caps_in;
               s_d.buf_known = buf_size_known_in;
               s_d.idx = 4'h0;
               s_d.hdr = 1'b1;
               s_d.busy = 1'b1;
               s_d.qrdy = 1'b0;
            end
         end
         crb_pkg::ST_SEND: begin
            push = buf_in_ready;
            if (push) begin
               s_d.idx = s_q.idx + 4'h1;
               if (s_q.idx == crb_pkg::LAST_WORD) begin
                  s_d.st = crb_pkg::ST_DONE;
               end
            end
         end
         crb_pkg::ST_DONE: begin
            // Checksum word follows the payload, then wait for drain
            if (s_q.idx == 4'h8) begin
               buf_in.data = checksum_in;
               buf_in.last = 1'b1;
               push = buf_in_ready;
               if (push) begin
                  s_d.idx = 4'h9;
               end
            end else if (!buf_out_valid) begin
               s_d.st = crb_pkg::ST_IDLE;
               s_d.busy = 1'b0;
            end
         end
         default: begin
            s_d.st = crb_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '{st: crb_pkg::ST_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Payload buffer toward the framer
   crb_skid #(
      .WIDTH(33)
   ) u_skid (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .in_valid_in(push),
      .in_ready_out(buf_in_ready),
      .in_data_in(buf_in),
      .out_valid_out(buf_out_valid),
      .out_ready_in(word_ready_in),
      .out_data_out(buf_out)
   );

   assign query_ready_out = s_q.qrdy;
   assign hdr_start_out = s_q.hdr;
   assign resp_type_out = crb_pkg::RESP_TYPE;
   assign busy_out = s_q.busy;
   assign word_valid_out = buf_out_valid;
   assign word_data_out = buf_out.data;
   assign word_last_out = buf_out.last;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_query_starts_send: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      query_valid_in && query_ready_out |=> hdr_start_out && busy_out) else $error("query not taken");
   a_flag_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      flags[31:7] == 25'h0 && flags[6:5] != 2'h3) else $error("reserved flag bits set");
   a_flag_bit_map: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      flags[4:0] == {s_q.caps.all_mcast, s_q.caps.mc_to_nc_fc, s_q.caps.nc_to_mc_fc,
                     s_q.caps.drv_status, s_q.caps.hw_arb}) else $error("flag bits misplaced");
   a_vlan_count_max: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      counts[31:24] <= 8'h0F) else $error("vlan count above 15");
   a_mac_total_max: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      10'(counts[23:16]) + 10'(counts[15:8]) + 10'(counts[7:0]) <= 10'h008
      && (counts[23:16] != 8'h00 || counts[7:0] != 8'h00)) else $error("mac filter total bad");
   a_buffer_unknown_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_q.idx == 4'h4 && !s_q.buf_known |-> cur_word == 32'h0) else $error("unknown buffer nonzero");
   a_reason_generic: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_q.st == crb_pkg::ST_SEND && s_q.idx == 4'h0 |-> cur_word[15:0] <= 16'h0001) else $error("bad reason");
   a_word_vlan_rsvd: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_q.idx == 4'h7 |-> cur_word[31:16] == 16'h0) else $error("reserved bytes set");
   a_word_stall_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_data_out)) else $error("word lost");
   a_last_on_checksum: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      push && buf_in.last |-> s_q.st == crb_pkg::ST_DONE && s_q.idx == 4'h8) else $error("last flag misplaced");
   c_error_query: cover property (@(posedge clk_in) disable iff (!rst_b_in) query_valid_in && query_error_in);
   c_last_word: cover property (@(posedge clk_in) disable iff (!rst_b_in) word_valid_out && word_last_out);
   c_stall: cover property (@(posedge clk_in) disable iff (!rst_b_in) (word_valid_out && !word_ready_in) [*3]);
   c_reserved_arb: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      s_q.busy && s_q.caps.arb_impl == crb_pkg::ARB_IMPL_RSVD);
   c_mac_clamp: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      s_q.busy && s_q.caps.ucast_count == 8'h00 && s_q.caps.mixed_count == 8'h00);

endmodule : crb_builder

// [core/crb_limit.sv]
`timescale 1ns/10ps
// Clamps filter counts to their legal ranges
module crb_limit (
   input wire logic [7:0] vlan_in,
   input wire logic [7:0] mixed_in,
   input wire logic [7:0] mcast_in,
   input wire logic [7:0] ucast_in,
   output logic [31:0] counts_out
);

   logic [7:0] vlan_c;
   logic [7:0] mixed_c;
   logic [7:0] mcast_c;
   logic [7:0] ucast_c;
   logic [8:0] left;

   // ----------------------------------------
   // Clamping
   // ----------------------------------------
   always_comb begin
      vlan_c = (vlan_in > crb_pkg::VLAN_FILTER_MAX) ? crb_pkg::VLAN_FILTER_MAX : vlan_in;
      ucast_c = (ucast_in > crb_pkg::MAC_FILTER_MAX[7:0]) ? crb_pkg::MAC_FILTER_MAX[7:0] : ucast_in;
      left = crb_pkg::MAC_FILTER_MAX - {1'b0, ucast_c};
      mixed_c = ({1'b0, mixed_in} > left) ? left[7:0] : mixed_in;
      left = left - {1'b0, mixed_c};
      mcast_c = ({1'b0, mcast_in} > left) ? left[7:0] : mcast_in;
      // At least one unicast or mixed filter is always reported
      if (ucast_c == 8'h00 && mixed_c == 8'h00) begin
         ucast_c = 8'h01;
         if (mcast_c == crb_pkg::MAC_FILTER_MAX[7:0]) begin
            mcast_c = mcast_c - 8'h01;
         end
      end
      counts_out = {vlan_c, mixed_c, mcast_c, ucast_c};
   end

endmodule : crb_limit

// [core/crb_pkg.sv]
package crb_pkg;

   // ----------------------------------------
   // Response framing
   // ----------------------------------------
   localparam logic [7:0] RESP_TYPE = 8'h96;
   localparam int HDR_BYTES = 16;
   localparam int RC_OFS = 16;
   localparam int FLAGS_OFS = 20;
   localparam int BCAST_OFS = 24;
   localparam int MCAST_OFS = 28;
   localparam int BUF_OFS = 32;
   localparam int AEN_OFS = 36;
   localparam int COUNT_OFS = 40;
   localparam int VLAN_OFS = 44;
   localparam int CSUM_OFS = 48;
   localparam int PAYLOAD_WORDS = 8;
   localparam logic [3:0] LAST_WORD = 4'h7;

   // ----------------------------------------
   // Capability flag positions
   // ----------------------------------------
   localparam int FLAG_HW_ARB = 0;
   localparam int FLAG_DRV_STATUS = 1;
   localparam int FLAG_NC_TO_MC_FC = 2;
   localparam int FLAG_MC_TO_NC_FC = 3;
   localparam int FLAG_ALL_MCAST = 4;
   localparam int FLAG_ARB_IMPL_LO = 5;
   localparam logic [1:0] ARB_IMPL_RSVD = 2'h3;

   // ----------------------------------------
   // Count limits and generic reason codes
   // ----------------------------------------
   localparam logic [7:0] VLAN_FILTER_MAX = 8'h0F;
   localparam logic [8:0] MAC_FILTER_MAX = 9'h008;
   localparam logic [15:0] RESP_OK = 16'h0000;
   localparam logic [15:0] RESP_FAILED = 16'h0001;
   localparam logic [15:0] REASON_NONE = 16'h0000;
   localparam logic [15:0] REASON_GENERIC_ERR = 16'h0001;

   // Capability inputs of the channel
   typedef struct packed {
      logic hw_arb;
      logic drv_status;
      logic nc_to_mc_fc;
      logic mc_to_nc_fc;
      logic all_mcast;
      logic [1:0] arb_impl;
      logic [31:0] bcast_caps;
      logic [31:0] mcast_caps;
      logic [31:0] buf_bytes;
      logic [31:0] aen_caps;
      logic [7:0] vlan_count;
      logic [7:0] mixed_count;
      logic [7:0] mcast_count;
      logic [7:0] ucast_count;
      logic [7:0] vlan_modes;
      logic [7:0] channel_count;
   } crb_caps_type;

   // One outgoing payload word
   typedef struct packed {
      logic [31:0] data;
      logic last;
   } crb_word_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SEND = 3'h2,
      ST_DONE = 3'h4
   } crb_state_type;

endpackage : crb_pkg

// [core/crb_skid.sv]
`timescale 1ns/10ps
// Two-entry buffer; a stall downstream never drops a word
module crb_skid #(
   parameter int WIDTH = 33
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);

   typedef struct packed {
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
      logic [1:0] cnt;
   } crb_skid_state_type;

   crb_skid_state_type s_q;
   crb_skid_state_type s_d;
   logic push;
   logic pop;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      push = in_valid_in && (s_q.cnt != 2'h2);
      pop = out_ready_in && (s_q.cnt != 2'h0);
      if (pop) begin
         s_d.d0 = s_q.d1;
      end
      if (push) begin
         if (s_d.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
            s_d.d0 = in_data_in;
         end else begin
            s_d.d1 = in_data_in;
         end
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   // State register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready_out = (s_q.cnt != 2'h2);
   assign out_valid_out = (s_q.cnt != 2'h0);
   assign out_data_out = s_q.d0;

   a_skid_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_q.cnt != 2'h3) else $error("buffer count out of range");

endmodule : crb_skid

// [test/crb_sink.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Receiver of response words
// ----------------------------------------
module crb_sink (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [31:0] word_data_in,
   input wire logic word_valid_in,
   input wire logic word_last_in,
   input wire logic stall_in,
   output logic word_ready_out
);
   logic [31:0] word_q[$];
   logic last_q[$];
   logic [1:0] phase_q;

   // Ready is high one cycle in four while stalling, so both buffer entries fill
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase_q <= 2'h0;
         word_ready_out <= 1'b0;
      end else begin
         phase_q <= phase_q + 2'h1;
         word_ready_out <= stall_in ? (phase_q == 2'h3) : 1'b1;
      end
   end

   // Store every accepted word with its last flag
   always @(posedge clk_in) begin
      if (rst_b_in && word_valid_in && word_ready_out) begin
         word_q.push_back(word_data_in);
         last_q.push_back(word_last_in);
      end
   end
endmodule : crb_sink

// [test/test_capabilities_response_builder.sv]
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
// ----------------------------------------
// Bench top
// ----------------------------------------
module test_capabilities_response_builder;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic query_valid = 1'b0;
   logic query_error = 1'b0;
   logic buf_known = 1'b0;
   logic stall = 1'b0;
   logic [31:0] checksum = 32'h00000000;
   crb_pkg::crb_caps_type caps = '0;
   logic [23:0] mac_exp = 24'h010203;
   logic query_ready, hdr_start, word_valid, word_last, word_ready, busy;
   logic [7:0] resp_type;
   logic [31:0] word_data;
   int failures = 0;
   int tests_run = 0;
   int hdr_cnt = 0;
   int cycles = 0;

   always #4 clk_in = ~clk_in;

   crb_builder dut (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .query_valid_in(query_valid),
      .query_error_in(query_error),
      .caps_in(caps),
      .buf_size_known_in(buf_known),
      .checksum_in(checksum),
      .query_ready_out(query_ready),
      .hdr_start_out(hdr_start),
      .resp_type_out(resp_type),
      .word_data_out(word_data),
      .word_valid_out(word_valid),
      .word_last_out(word_last),
      .word_ready_in(word_ready),
      .busy_out(busy)
   );

   crb_sink sink (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .word_data_in(word_data),
      .word_valid_in(word_valid),
      .word_last_in(word_last),
      .stall_in(stall),
      .word_ready_out(word_ready)
   );

   // Header pulses and run-length guard
   always @(posedge clk_in) begin
      if (hdr_start === 1'b1) hdr_cnt++;
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("Error at %0t: run too long", $time);
         test_done();
      end
   end

   // Expected payload word by index
   function automatic logic [31:0] exp_w(input int idx, input logic err);
      logic [7:0] vlan;
      vlan = (caps.vlan_count > 8'h0F) ? 8'h0F : caps.vlan_count;
      case (idx)
         0: return err ? {crb_pkg::RESP_FAILED, crb_pkg::REASON_GENERIC_ERR} :
                         {crb_pkg::RESP_OK, crb_pkg::REASON_NONE};
         1: return {25'h0000000, (caps.arb_impl == 2'h3) ? 2'h0 : caps.arb_impl, caps.all_mcast,
                    caps.mc_to_nc_fc, caps.nc_to_mc_fc, caps.drv_status, caps.hw_arb};
         2: return caps.bcast_caps;
         3: return caps.mcast_caps;
         4: return buf_known ? caps.buf_bytes : 32'h00000000;
         5: return caps.aen_caps;
         6: return {vlan, mac_exp};
         7: return {16'h0000, caps.vlan_modes, caps.channel_count};
         default: return checksum;
      endcase
   endfunction : exp_w

   // Issue one query, collect the response and check it
   task automatic run_q(input logic err);
      int n;
      sink.word_q.delete();
      sink.last_q.delete();
      hdr_cnt = 0;
      @(negedge clk_in);
      query_valid = 1'b1;
      query_error = err;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (query_ready !== 1'b1 && n < 50);
      if (query_ready !== 1'b1) begin
         failures++;
         $display("Error at %0t: query never taken", $time);
      end
      @(negedge clk_in);
      query_valid = 1'b0;
      n = 0;
      while ((sink.word_q.size() < 9 || busy !== 1'b0) && n < 200) begin
         @(negedge clk_in);
         n++;
      end
      if (sink.word_q.size() < 9 || busy !== 1'b0) begin
         failures++;
         $display("Error at %0t: response never finished", $time);
      end
      repeat (4) @(negedge clk_in);
      `CHK(sink.word_q.size(), 9)
      `CHK(hdr_cnt, 1)
      `CHK(resp_type, 8'h96)
      for (int k = 0; k < 9 && k < sink.word_q.size(); k++) begin
         `CHK(sink.word_q[k], exp_w(k, err))
         `CHK(sink.last_q[k], k == 8)
      end
      if (sink.last_q.size() == 9) `CHK(sink.last_q[8], 1'b1)
   endtask : run_q

   // Print counts and verdict
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // Main sequence: every arbitration state, error and stall cases, count clamp
   initial begin
      repeat (16) @(negedge clk_in);
      rst_b_in = 1'b1;
      for (int i = 0; i < 5; i++) begin
         caps.hw_arb = i[0];
         caps.drv_status = ~i[0];
         caps.nc_to_mc_fc = i[1];
         caps.mc_to_nc_fc = ~i[1];
         caps.all_mcast = (i == 3);
         caps.arb_impl = i[1:0];
         caps.bcast_caps = 32'h0000000F >> i;
         caps.mcast_caps = 32'h00000007 << i;
         caps.buf_bytes = 32'h00002000 + i;
         caps.aen_caps = 32'h00000003 ^ i;
         caps.vlan_count = (i == 4) ? 8'h14 : 8'h03 + i;
         // Scenario 3 overflows the total, scenario 4 has no unicast or mixed filter
         caps.mixed_count = (i == 3) ? 8'h05 : (i == 4) ? 8'h00 : 8'h01;
         caps.mcast_count = (i == 3) ? 8'h04 : (i == 4) ? 8'h08 : 8'h02;
         caps.ucast_count = (i == 3) ? 8'h03 : (i == 4) ? 8'h00 : 8'h03;
         mac_exp = (i == 3) ? 24'h050003 : (i == 4) ? 24'h000701 : 24'h010203;
         caps.vlan_modes = 8'h07;
         caps.channel_count = 8'h02 + i;
         checksum = 32'hA5C30000 + i;
         buf_known = (i != 1);
         stall = i[0];
         run_q(i == 2);
      end
      test_done();
   end
endmodule : test_capabilities_response_builder
